// ### verilog/smb_block_write_target.sv
`timescale 1ns/10ps
module smb_block_write_target
   import smb_cfg_pkg::*;
#(
   parameter int                             NB         = 16,
   parameter int                             FIFO_DEPTH = 8,
   parameter logic [smb_cfg_pkg::ADDR_W-1:0] ADDR_SEL0  = 7'h10,
   parameter logic [smb_cfg_pkg::ADDR_W-1:0] ADDR_SEL1  = 7'h12
) (
   input  wire logic                             I_CLK,
   input  wire logic                             I_ARST_N,
   input  wire logic                             I_SCL,
   input  wire logic                             I_SDA,
   input  wire logic                             I_ADDR_SELECT_PIN,
   input  wire logic                             I_PD_N,
   input  wire logic                             I_CFG_HOLD,
   output logic                                  O_SCL_O,
   output logic                                  O_SCL_OE,
   output logic                                  O_SDA_O,
   output logic                                  O_SDA_OE,
   output logic                                  O_DIF_RUN,
   output logic                                  O_REF_RUN,
   output logic [smb_cfg_pkg::SLEW_W-1:0]        O_REF_SLEW
);
   import smb_cfg_pkg::*;

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   typedef struct packed {
      logic [PIN_NUM-1:0] s1;
      logic [PIN_NUM-1:0] s2;
      logic [PIN_NUM-1:0] s3;
      logic [PIN_NUM-1:0] filt;
      logic [1:0]         warm;
      logic               sel_done;
      logic               sel_val;
      link_st_e           st;
      phase_e             ph;
      logic [3:0]         bitcnt;
      logic [7:0]         sh;
      logic [7:0]         idx;
      logic [7:0]         left;
      logic               sda_oe;
      logic               scl_oe;
      logic               sda_o;
      logic               scl_o;
      logic [NB-1:0][7:0] cfg;
      logic               dif_run;
      logic               ref_run;
      logic [SLEW_W-1:0]  slew;
   } top_s;

   function automatic top_s rst_state();
      top_s r;
      r                   = '0;
      r.st                = ST_IDLE;
      r.ph                = PH_ADDR;
      for (int i = 0; i < NB; i++) begin
         r.cfg[i] = CFG_BYTE_RST;
      end
      r.cfg[REF_BYTE_IDX] = REF_BYTE_RST;
      r.slew              = REF_BYTE_RST[SLEW_MSB:SLEW_LSB];
      return r;
   endfunction

   localparam top_s RST_S = rst_state();

   top_s q;
   top_s d;

   cfg_stream_if #(.W(ENTRY_W)) push_if ();
   cfg_stream_if #(.W(ENTRY_W)) pop_if ();

   logic       pop_fire;
   logic       push_fire;
   logic [7:0] pop_idx;
   logic       pd;

   // --------------------------------------------------------------
   // buffer between link and configuration array
   // --------------------------------------------------------------
   cfg_fifo #(
      .W     (ENTRY_W),
      .DEPTH (FIFO_DEPTH)
   ) u_fifo (
      .i_clk    (I_CLK),
      .i_arst_n (I_ARST_N),
      .wr       (push_if),
      .rd       (pop_if)
   );

   assign push_if.valid = (q.st == ST_STRETCH);
   assign push_if.data  = {q.idx, q.sh};
   assign push_fire     = push_if.valid && push_if.ready;
   // hold input lets the array side stall; the link stretches clock once the queue is full
   assign pop_if.ready  = !I_CFG_HOLD;
   assign pop_fire      = pop_if.valid && pop_if.ready;
   assign pop_idx       = pop_if.data[ENTRY_W-1:8];
   assign pd            = !q.filt[PIN_PD];

   // --------------------------------------------------------------
   // next state
   // --------------------------------------------------------------
   always_comb begin
      logic              scl_rise;
      logic              scl_fall;
      logic              start_c;
      logic              stop_c;
      logic [ADDR_W-1:0] my_addr;
      scl_rise = 1'b0;
      scl_fall = 1'b0;
      start_c  = 1'b0;
      stop_c   = 1'b0;
      my_addr  = q.sel_val ? ADDR_SEL1 : ADDR_SEL0;
      d        = q;
      d.s1     = {I_PD_N, I_ADDR_SELECT_PIN, I_SDA, I_SCL};
      d.s2     = q.s1;
      d.s3     = q.s2;
      // level accepted only once two late stages agree
      for (int i = 0; i < PIN_NUM; i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.filt[i] = q.s2[i];
         end
      end
      scl_rise = !q.filt[PIN_SCL] && d.filt[PIN_SCL];
      scl_fall = q.filt[PIN_SCL] && !d.filt[PIN_SCL];
      start_c  = q.filt[PIN_SCL] && d.filt[PIN_SCL]
                 && q.filt[PIN_SDA] && !d.filt[PIN_SDA];
      stop_c   = q.filt[PIN_SCL] && d.filt[PIN_SCL]
                 && !q.filt[PIN_SDA] && d.filt[PIN_SDA];

      if (q.warm != WARM_CNT) begin
         d.warm = q.warm + 2'h1;
      end else if (!q.sel_done && (q.s2[PIN_SEL] == q.s3[PIN_SEL])) begin
         d.sel_done = 1'b1;
         d.sel_val  = q.s2[PIN_SEL];
      end

      if (stop_c) begin
         d.st     = ST_IDLE;
         d.sda_oe = 1'b0;
         d.scl_oe = 1'b0;
      end else if (start_c) begin
         d.st     = ST_RX;
         d.ph     = PH_ADDR;
         d.bitcnt = '0;
         d.sda_oe = 1'b0;
         d.scl_oe = 1'b0;
      end else begin
         unique case (q.st)
            ST_IDLE: begin
            end
            ST_RX: begin
               if (scl_rise && (q.bitcnt < BYTE_BITS)) begin
                  d.sh     = {q.sh[6:0], d.filt[PIN_SDA]};
                  d.bitcnt = q.bitcnt + 4'h1;
               end else if (scl_fall && (q.bitcnt == BYTE_BITS)) begin
                  d.st     = ST_ACK;
                  d.sda_oe = 1'b1;
                  unique case (q.ph)
                     PH_ADDR: begin
                        // read direction and foreign address are not ours
                        if (q.sh != {my_addr, WR_DIR}) begin
                           d.st     = ST_IGNORE;
                           d.sda_oe = 1'b0;
                        end
                     end
                     PH_IDX: d.idx = q.sh;
                     PH_CNT: d.left = q.sh;
                     PH_DATA: begin
                        // bytes beyond the count are not acknowledged
                        d.sda_oe = 1'b0;
                        if (q.left != 8'h00) begin
                           d.st     = ST_STRETCH;
                           d.scl_oe = 1'b1;
                        end else begin
                           d.st = ST_IGNORE;
                        end
                     end
                  endcase
               end
            end
            ST_STRETCH: begin
               // ack only once byte is queued
               if (push_if.ready) begin
                  d.scl_oe = 1'b0;
                  d.sda_oe = 1'b1;
                  d.st     = ST_ACK;
                  d.idx    = q.idx + 8'h01;
                  d.left   = q.left - 8'h01;
               end
            end
            ST_ACK: begin
               if (scl_fall) begin
                  d.sda_oe = 1'b0;
                  d.st     = ST_RX;
                  d.bitcnt = '0;
                  unique case (q.ph)
                     PH_ADDR: d.ph = PH_IDX;
                     PH_IDX:  d.ph = PH_CNT;
                     PH_CNT:  d.ph = PH_DATA;
                     PH_DATA: d.ph = PH_DATA;
                  endcase
               end
            end
            ST_IGNORE: begin
            end
            default: begin
               d.st     = ST_IDLE;
               d.sda_oe = 1'b0;
               d.scl_oe = 1'b0;
            end
         endcase
      end

      // array written as each entry with index below NB drains
      if (pop_fire && (int'(pop_idx) < NB)) begin
         d.cfg[pop_idx] = pop_if.data[7:0];
      end

      d.slew    = q.cfg[REF_BYTE_IDX][SLEW_MSB:SLEW_LSB];
      d.dif_run = !pd;
      d.ref_run = pd ? q.cfg[REF_BYTE_IDX][WOL_BIT]
                     : q.cfg[REF_BYTE_IDX][REF_OE_BIT];
   end

   always_ff @(posedge I_CLK or negedge I_ARST_N) begin
      if (!I_ARST_N) begin
         q <= RST_S;
      end else begin
         q <= d;
      end
   end

   assign O_SCL_O    = q.scl_o;
   assign O_SCL_OE   = q.scl_oe;
   assign O_SDA_O    = q.sda_o;
   assign O_SDA_OE   = q.sda_oe;
   assign O_DIF_RUN  = q.dif_run;
   assign O_REF_RUN  = q.ref_run;
   assign O_REF_SLEW = q.slew;

   // --------------------------------------------------------------
   // assertions
   // --------------------------------------------------------------
   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!I_ARST_N);

   property p_ack_drive;
      (q.st == ST_ACK) |-> O_SDA_OE && !O_SCL_OE;
   endproperty
   a_ack_drive: assert property (p_ack_drive)
      else $error("ack phase without sda drive");

   property p_queue_then_ack;
      push_fire |=> (q.st == ST_ACK) && O_SDA_OE && !O_SCL_OE;
   endproperty
   a_queue_then_ack: assert property (p_queue_then_ack)
      else $error("queued byte not acknowledged next cycle");

   property p_index_step;
      push_fire |=> (q.idx == 8'($past(q.idx) + 8'h01));
   endproperty
   a_index_step: assert property (p_index_step)
      else $error("index did not advance by one");

   property p_sel_latched;
      q.sel_done |=> q.sel_done && $stable(q.sel_val);
   endproperty
   a_sel_latched: assert property (p_sel_latched)
      else $error("address select changed after latch");

   property p_pd_wake;
      pd && q.cfg[REF_BYTE_IDX][WOL_BIT] |=> O_REF_RUN && !O_DIF_RUN;
   endproperty
   a_pd_wake: assert property (p_pd_wake)
      else $error("wake power down gating wrong");

   property p_pd_off;
      pd && !q.cfg[REF_BYTE_IDX][WOL_BIT] |=> !O_REF_RUN && !O_DIF_RUN;
   endproperty
   a_pd_off: assert property (p_pd_off)
      else $error("power down left an output running");

   property p_slew;
      1'b1 |=> (O_REF_SLEW == $past(q.cfg[REF_BYTE_IDX][SLEW_MSB:SLEW_LSB]));
   endproperty
   a_slew: assert property (p_slew)
      else $error("slew code not following byte 3");

   property p_store;
      pop_fire && (int'(pop_idx) < NB) |=>
         (q.cfg[$past(pop_idx)] == $past(pop_if.data[7:0]));
   endproperty
   a_store: assert property (p_store)
      else $error("drained byte not stored");

   c_addr_ack: cover property ((q.st == ST_ACK) && (q.ph == PH_ADDR));
   c_data_push: cover property (push_fire);
   c_stretch_wait: cover property ((q.st == ST_STRETCH) && !push_if.ready);
   c_wake: cover property (pd && O_REF_RUN);
endmodule

// ### inc/smb_cfg_pkg.sv
package smb_cfg_pkg;

   // --------------------------------------------------------------
   // pin synchroniser slots
   // --------------------------------------------------------------
   localparam int PIN_NUM = 4;
   localparam int PIN_SCL = 0;
   localparam int PIN_SDA = 1;
   localparam int PIN_SEL = 2;
   localparam int PIN_PD  = 3;
   localparam logic [1:0] WARM_CNT = 2'h3;

   // --------------------------------------------------------------
   // serial framing
   // --------------------------------------------------------------
   localparam int         ADDR_W    = 7;
   localparam logic [3:0] BYTE_BITS = 4'h8;
   localparam logic       WR_DIR    = 1'b0;
   localparam int         ENTRY_W   = 16;

   // --------------------------------------------------------------
   // configuration byte layout
   // --------------------------------------------------------------
   localparam logic [7:0] REF_BYTE_IDX = 8'h03;
   localparam int         WOL_BIT      = 5;
   localparam int         REF_OE_BIT   = 4;
   localparam int         SLEW_MSB     = 7;
   localparam int         SLEW_LSB     = 6;
   localparam int         SLEW_W       = 2;
   localparam logic [7:0] REF_BYTE_RST = 8'h5F;
   localparam logic [7:0] CFG_BYTE_RST = 8'h00;

   // --------------------------------------------------------------
   // states
   // --------------------------------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE,
      ST_RX,
      ST_ACK,
      ST_STRETCH,
      ST_IGNORE
   } link_st_e;

   typedef enum logic [1:0] {
      PH_ADDR,
      PH_IDX,
      PH_CNT,
      PH_DATA
   } phase_e;

endpackage

// ### inc/cfg_stream_if.sv
`timescale 1ns/10ps
interface cfg_stream_if #(
   parameter int W = 16
) ();
   logic         valid;
   logic         ready;
   logic [W-1:0] data;

   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface

// ### verilog/cfg_fifo.sv
`timescale 1ns/10ps
module cfg_fifo #(
   parameter int W     = 16,
   parameter int DEPTH = 8
) (
   input wire logic   i_clk,
   input wire logic   i_arst_n,
   cfg_stream_if.snk  wr,
   cfg_stream_if.src  rd
);
   // depth must be a power of two: pointers wrap by overflow
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][W-1:0] mem;
      logic [AW:0]             wp;
      logic [AW:0]             rp;
   } fifo_s;

   fifo_s q;
   fifo_s d;
   logic  full;
   logic  empty;

   assign empty    = (q.wp == q.rp);
   assign full     = (q.wp[AW-1:0] == q.rp[AW-1:0]) && (q.wp[AW] != q.rp[AW]);
   assign wr.ready = !full;
   assign rd.valid = !empty;
   assign rd.data  = q.mem[q.rp[AW-1:0]];

   always_comb begin
      d = q;
      if (wr.valid && !full) begin
         d.mem[q.wp[AW-1:0]] = wr.data;
         d.wp                = q.wp + 1'b1;
      end
      if (rd.ready && !empty) begin
         d.rp = q.rp + 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end
endmodule

// ### verif/smb_host_model.sv
`timescale 1ns/10ps
module smb_host_model
   import smb_cfg_pkg::*;
(
   input  wire logic i_clk,
   input  wire logic i_scl,
   input  wire logic i_sda,
   output logic      o_scl_low,
   output logic      o_sda_low
);
   // --------------------------------------------------------------
   // bus phases
   // --------------------------------------------------------------
   // six clocks a phase stays clear of the three-flop filter
   localparam int PH = 6;

   initial begin
      o_scl_low = 1'b0;
      o_sda_low = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // bounded so a stuck stretch cannot hang the host
   task automatic rise_scl();
      int w;
      o_scl_low = 1'b0;
      w = 0;
      while (!i_scl && w < 4000) begin
         tick(1);
         w++;
      end
      tick(PH);
   endtask

   task automatic put_bit(input logic b, output logic s);
      o_sda_low = !b;
      tick(PH);
      rise_scl();
      s = i_sda;
      o_scl_low = 1'b1;
      tick(PH);
   endtask

   task automatic wr_byte(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         put_bit(d[i], s);
      end
      put_bit(1'b1, s);
      ack = !s;
   endtask

   // --------------------------------------------------------------
   // block write
   // --------------------------------------------------------------
   // start, address, index, count
   task automatic xfer(input logic [7:0] a, input logic [7:0] n,
                       input logic [7:0] x, input int nd,
                       input logic [7:0] v3, output int acks);
      logic k;
      acks = 0;
      o_sda_low = 1'b0;
      tick(PH);
      rise_scl();
      o_sda_low = 1'b1;
      tick(PH);
      o_scl_low = 1'b1;
      tick(PH);
      wr_byte(a, k);
      if (k) begin
         acks = 1;
         wr_byte(n, k);
         acks += int'(k);
         wr_byte(x, k);
         acks += int'(k);
         for (int i = 0; i < nd; i++) begin
            wr_byte((n + 8'(i) == REF_BYTE_IDX) ? v3 : 8'h00, k);
            acks += int'(k);
         end
      end
      o_sda_low = 1'b1;
      tick(PH);
      rise_scl();
      o_sda_low = 1'b0;
      tick(PH);
   endtask
endmodule

// ### verif/smb_block_write_target_test.sv
`timescale 1ns/10ps
module smb_block_write_target_test;
   import smb_cfg_pkg::*;
   localparam logic [6:0] A0 = 7'h10;
   localparam logic [6:0] A1 = 7'h12;

   logic              clk;
   logic              arst_n;
   logic              sel_pin;
   logic              pd_n;
   logic              hold;
   logic              scl_oe;
   logic              sda_oe;
   logic              scl_o;
   logic              sda_o;
   logic              dif_run;
   logic              ref_run;
   logic [SLEW_W-1:0] slew;
   logic              h_scl_low;
   logic              h_sda_low;
   wire logic         scl_w;
   wire logic         sda_w;
   int                fail_count;
   int                samples_checked;
   int                cycles;
   int                acks;

   // --------------------------------------------------------------
   // wires, dut, host
   // --------------------------------------------------------------
   // pulled up: low only while some party pulls
   assign scl_w = !(h_scl_low || scl_oe);
   assign sda_w = !(h_sda_low || sda_oe);

   smb_block_write_target #(
      .NB         (16),
      .FIFO_DEPTH (8),
      .ADDR_SEL0  (A0),
      .ADDR_SEL1  (A1)
   ) u_dut (
      .I_CLK             (clk),
      .I_ARST_N          (arst_n),
      .I_SCL             (scl_w),
      .I_SDA             (sda_w),
      .I_ADDR_SELECT_PIN (sel_pin),
      .I_PD_N            (pd_n),
      .I_CFG_HOLD        (hold),
      .O_SCL_O           (scl_o),
      .O_SCL_OE          (scl_oe),
      .O_SDA_O           (sda_o),
      .O_SDA_OE          (sda_oe),
      .O_DIF_RUN         (dif_run),
      .O_REF_RUN         (ref_run),
      .O_REF_SLEW        (slew)
   );

   smb_host_model u_host (
      .i_clk     (clk),
      .i_scl     (scl_w),
      .i_sda     (sda_w),
      .o_scl_low (h_scl_low),
      .o_sda_low (h_sda_low)
   );

   always #50 clk = ~clk;

   // --------------------------------------------------------------
   // checking and closing
   // --------------------------------------------------------------
   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   always @(posedge clk) begin
      cycles++;
      if (cycles == 60000) begin
         fail_count++;
         summarize();
      end
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge clk);
   endtask

   // --------------------------------------------------------------
   // scenarios
   // --------------------------------------------------------------
   task automatic t_reset();
      check("slew", 8'(slew), 8'h01);
      check("ref", 8'(ref_run), 8'h01);
      check("dif", 8'(dif_run), 8'h01);
      // open-drain pins only ever pull low
      check("scl level", 8'(scl_o), 8'h00);
      check("sda level", 8'(sda_o), 8'h00);
      pd_n = 1'b0;
      wait_clk(6);
      check("dif pd", 8'(dif_run), 8'h00);
      check("ref pd", 8'(ref_run), 8'h00);
      pd_n = 1'b1;
      wait_clk(6);
   endtask

   task automatic t_slew();
      logic [7:0] codes [4];
      codes = '{8'h1F, 8'h5F, 8'h9F, 8'hDF};
      for (int i = 0; i < 4; i++) begin
         u_host.xfer({A0, 1'b0}, 8'h03, 8'h01, 1, codes[i], acks);
         wait_clk(4);
         check("acks", 8'(acks), 8'h04);
         check("slew", 8'(slew), 8'(i));
      end
   endtask

   // one byte past the count must be refused
   task automatic t_count();
      u_host.xfer({A0, 1'b0}, 8'h02, 8'h02, 3, 8'h9F, acks);
      wait_clk(4);
      check("acks", 8'(acks), 8'h05);
      check("slew", 8'(slew), 8'h02);
   endtask

   task automatic t_abort();
      u_host.xfer({A0, 1'b0}, 8'h03, 8'h04, 1, 8'hDF, acks);
      wait_clk(4);
      check("acks", 8'(acks), 8'h04);
      check("slew", 8'(slew), 8'h03);
   endtask

   task automatic t_addr();
      sel_pin = 1'b1;
      u_host.xfer({A1, 1'b0}, 8'h03, 8'h01, 1, 8'h1F, acks);
      check("acks", 8'(acks), 8'h00);
      u_host.xfer({A0, 1'b1}, 8'h03, 8'h01, 1, 8'h1F, acks);
      check("acks", 8'(acks), 8'h00);
      check("slew", 8'(slew), 8'h03);
      u_host.xfer({A0, 1'b0}, 8'h03, 8'h01, 1, 8'h1F, acks);
      wait_clk(4);
      check("acks", 8'(acks), 8'h04);
      check("slew", 8'(slew), 8'h00);
   endtask

   // stalled drain fills the queue, ninth byte must stretch
   task automatic t_hold();
      int c;
      int w;
      hold = 1'b1;
      fork
         u_host.xfer({A0, 1'b0}, 8'h00, 8'h09, 9, 8'h5F, acks);
         begin
            c = 0;
            w = 0;
            while (c < 20 && w < 4000) begin
               wait_clk(1);
               c = scl_oe ? c + 1 : 0;
               w++;
            end
            check("stretch", 8'(scl_oe), 8'h01);
            check("slew held", 8'(slew), 8'h00);
            hold = 1'b0;
         end
      join
      wait_clk(4);
      check("acks", 8'(acks), 8'h0C);
      check("slew", 8'(slew), 8'h01);
   endtask

   task automatic t_wol();
      u_host.xfer({A0, 1'b0}, 8'h03, 8'h01, 1, 8'h3F, acks);
      pd_n = 1'b0;
      wait_clk(6);
      check("ref wol", 8'(ref_run), 8'h01);
      check("dif wol", 8'(dif_run), 8'h00);
      u_host.xfer({A0, 1'b0}, 8'h03, 8'h01, 1, 8'h1F, acks);
      wait_clk(6);
      check("ref pd", 8'(ref_run), 8'h00);
      pd_n = 1'b1;
      wait_clk(6);
      check("dif", 8'(dif_run), 8'h01);
   endtask

   initial begin
      clk = 1'b0;
      arst_n = 1'b0;
      sel_pin = 1'b0;
      pd_n = 1'b1;
      hold = 1'b0;
      fail_count = 0;
      samples_checked = 0;
      cycles = 0;
      wait_clk(3);
      arst_n = 1'b1;
      wait_clk(12);
      t_reset();
      t_slew();
      t_count();
      t_abort();
      t_addr();
      t_hold();
      t_wol();
      summarize();
   end
endmodule
